/* verilog/srm_pkg.sv */
// ---------------------------------------------------------------------------
// How it works
// - After power-up the supply reset output is high and stays high until the supply has been good for the selected hold time.
// - While the main supply is below its trip level the supply reset output is high, until the supply has been back in range for the selected hold time.
// - A high manual reset input starts a reset cycle that drives the supply reset output high.
// - After the manual reset input returns low the supply reset output stays high for the selected hold time.
// - Two software-writable selection bits in the control and status register choose the hold time.
// - Each monitor output goes high while its input is above its own trip level.
// - Each monitor output goes low when its input falls below its own trip level.
// - Both monitor outputs are copied into latched volatile bits of the control and status register.
// - The latched monitor bits can be read by the host over the register port.
// - The third-input monitor output follows its comparator with no added delay or stretching.
// - The second-input monitor output follows its comparator directly with no power-up delay.
// ---------------------------------------------------------------------------

package srm_pkg;

    // -----------------------------------------------------------------------
    // Clock and timing
    // -----------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int NS_PER_MS = 1000000;
    localparam int HOLD_MS_0 = 50;
    localparam int HOLD_MS_1 = 100;
    localparam int HOLD_MS_2 = 200;
    localparam int HOLD_MS_3 = 400;

    // -----------------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CSR_OFFSET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h0c;

    localparam int CSR_SEL_LO_BIT = 0;
    localparam int CSR_SEL_HI_BIT = 1;
    localparam int CSR_MON_B_BIT = 2;
    localparam int CSR_MON_C_BIT = 3;
    localparam int CSR_RESET_BIT = 4;
    localparam logic [1:0] CSR_SEL_RESET = 2'h0;

    // -----------------------------------------------------------------------
    // Events and synchronised inputs
    // -----------------------------------------------------------------------
    localparam int EVT_W = 4;
    localparam int EVT_RST_ON = 0;
    localparam int EVT_RST_OFF = 1;
    localparam int EVT_MON_B = 2;
    localparam int EVT_MON_C = 3;
    localparam logic [EVT_W-1:0] IRQ_EN_RESET = 4'h0;

    localparam int IN_W = 4;
    localparam int IN_SUPPLY = 0;
    localparam int IN_MANUAL = 1;
    localparam int IN_MON_B = 2;
    localparam int IN_MON_C = 3;

    typedef enum logic [1:0] {
        SEQ_HOLD = 2'b00,
        SEQ_COUNT = 2'b01,
        SEQ_RUN = 2'b10
    } srm_seq_type;

endpackage

/* verilog/srm_sync_if.sv */
`timescale 1ns/1ns

interface srm_sync_if #(
    parameter int W = 4
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport syncer (input raw, output clean);
    modport user (output raw, input clean);
endinterface // srm_sync_if

/* verilog/srm_sync.sv */
`timescale 1ns/1ns

module srm_sync
    import srm_pkg::*;
#(
    parameter int W = 4
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Raw pins in, filtered levels out.
    srm_sync_if.syncer port
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } srm_sync_type;

    srm_sync_type sync_q;
    srm_sync_type sync_d;

    // -----------------------------------------------------------------------
    // Three stages
    // -----------------------------------------------------------------------
    // A level counts only once the second and third stage agree, so a
    // single metastable sample never reaches the sequencer.
    always_comb
    begin
        sync_d = sync_q;
        sync_d.s1 = port.raw;
        sync_d.s2 = sync_q.s1;
        sync_d.s3 = sync_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (sync_q.s2[i] == sync_q.s3[i])
            begin
                sync_d.clean[i] = sync_q.s3[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync_q <= '0;
        end
        else
        begin
            sync_q <= sync_d;
        end
    end

    assign port.clean = sync_q.clean;

    sync_agree_a: assert property (
        @(posedge clock) disable iff (srst)
        (sync_q.clean != $past(sync_q.clean)) |->
        ($past(sync_q.s2) == $past(sync_q.s3)))
    else $error("Synchronised level changed without stage agreement.");

endmodule // srm_sync

/* verilog/srm_top.sv */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns

module srm_top
    import srm_pkg::*;
#(
    parameter int CNT_W = 22,
    parameter int HOLD_CYC_0 =
        (HOLD_MS_0 * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int HOLD_CYC_1 =
        (HOLD_MS_1 * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int HOLD_CYC_2 =
        (HOLD_MS_2 * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int HOLD_CYC_3 =
        (HOLD_MS_3 * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator results and manual reset pin.
    input wire logic supply_ok_in,
    input wire logic manual_reset_in,
    input wire logic monitor_b_in,
    input wire logic monitor_c_in,
    // Open-drain outputs: level and pull-low enable.
    output logic supply_reset_out,
    output logic supply_reset_oe,
    output logic monitor_b_out,
    output logic monitor_b_oe,
    output logic monitor_c_out,
    output logic monitor_c_oe,
    // Interrupt.
    output logic irq
);

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        srm_seq_type seq;
        logic [CNT_W-1:0] cnt;
        logic rst_out;
        logic mon_b;
        logic mon_c;
        logic [1:0] sel;
        logic lat_b;
        logic lat_c;
        logic [EVT_W-1:0] irq_stat;
        logic [EVT_W-1:0] irq_en;
        logic [DATA_W-1:0] rdata;
        logic slverr;
        logic irq;
    } srm_top_type;

    localparam srm_top_type TOP_RESET = '{
        seq: SEQ_HOLD,
        cnt: '0,
        rst_out: 1'b1,
        mon_b: 1'b0,
        mon_c: 1'b0,
        sel: CSR_SEL_RESET,
        lat_b: 1'b0,
        lat_c: 1'b0,
        irq_stat: '0,
        irq_en: IRQ_EN_RESET,
        rdata: '0,
        slverr: 1'b0,
        irq: 1'b0
    };

    srm_top_type top_q;
    srm_top_type top_d;

    // -----------------------------------------------------------------------
    // Decoding helpers
    // -----------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] hold_term(input logic [1:0] sel);
        logic [CNT_W-1:0] term;
        case (sel)
            2'h0: term = CNT_W'(HOLD_CYC_0);
            2'h1: term = CNT_W'(HOLD_CYC_1);
            2'h2: term = CNT_W'(HOLD_CYC_2);
            default: term = CNT_W'(HOLD_CYC_3);
        endcase
        return term;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return addr == CSR_OFFSET || addr == IRQ_STATUS_OFFSET ||
            addr == IRQ_CLEAR_OFFSET || addr == IRQ_ENABLE_OFFSET;
    endfunction

    // -----------------------------------------------------------------------
    // Input synchroniser
    // -----------------------------------------------------------------------
    srm_sync_if #(.W(IN_W)) sync_bus ();

    assign sync_bus.raw[IN_SUPPLY] = supply_ok_in;
    assign sync_bus.raw[IN_MANUAL] = manual_reset_in;
    assign sync_bus.raw[IN_MON_B] = monitor_b_in;
    assign sync_bus.raw[IN_MON_C] = monitor_c_in;

    srm_sync #(.W(IN_W)) u_sync (
        .clock(clock),
        .srst(srst),
        .port(sync_bus.syncer)
    );

    logic supply_ok_s;
    logic manual_s;
    logic mon_b_s;
    logic mon_c_s;
    logic fault;
    logic apb_setup;
    logic apb_write;
    logic [CNT_W-1:0] term_cnt;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] clr;

    assign supply_ok_s = sync_bus.clean[IN_SUPPLY];
    assign manual_s = sync_bus.clean[IN_MANUAL];
    assign mon_b_s = sync_bus.clean[IN_MON_B];
    assign mon_c_s = sync_bus.clean[IN_MON_C];
    assign fault = ~supply_ok_s | manual_s;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;
    assign term_cnt = hold_term(top_q.sel);

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    always_comb
    begin
        top_d = top_q;
        evt = '0;
        clr = '0;

        // Reset sequencer. A brown-out or manual reset restarts the full
        // hold time, so a chattering supply cannot release reset early.
        case (top_q.seq)
            SEQ_HOLD:
            begin
                top_d.rst_out = 1'b1;
                top_d.cnt = '0;
                if (!fault)
                begin
                    top_d.seq = SEQ_COUNT;
                end
            end
            SEQ_COUNT:
            begin
                if (fault)
                begin
                    top_d.seq = SEQ_HOLD;
                end
                else if (top_q.cnt == term_cnt - 1'b1)
                begin
                    top_d.seq = SEQ_RUN;
                    top_d.rst_out = 1'b0;
                end
                else
                begin
                    top_d.cnt = top_q.cnt + 1'b1;
                end
            end
            SEQ_RUN:
            begin
                if (fault)
                begin
                    top_d.seq = SEQ_HOLD;
                    top_d.rst_out = 1'b1;
                end
            end
            default:
            begin
                top_d.seq = SEQ_HOLD;
                top_d.rst_out = 1'b1;
            end
        endcase

        // Monitor outputs follow the synchronised comparators directly.
        top_d.mon_b = mon_b_s;
        top_d.mon_c = mon_c_s;
        top_d.lat_b = top_q.mon_b;
        top_d.lat_c = top_q.mon_c;

        evt[EVT_RST_ON] = top_d.rst_out & ~top_q.rst_out;
        evt[EVT_RST_OFF] = ~top_d.rst_out & top_q.rst_out;
        evt[EVT_MON_B] = top_d.mon_b ^ top_q.mon_b;
        evt[EVT_MON_C] = top_d.mon_c ^ top_q.mon_c;

        // Register read is captured in the setup cycle, so the answer
        // comes from flip-flops with no wait state.
        if (apb_setup)
        begin
            top_d.slverr = ~addr_hit(paddr);
            top_d.rdata = '0;
            case (paddr)
                CSR_OFFSET:
                begin
                    top_d.rdata[CSR_SEL_HI_BIT:CSR_SEL_LO_BIT] = top_q.sel;
                    top_d.rdata[CSR_MON_B_BIT] = top_q.lat_b;
                    top_d.rdata[CSR_MON_C_BIT] = top_q.lat_c;
                    top_d.rdata[CSR_RESET_BIT] = top_q.rst_out;
                end
                IRQ_STATUS_OFFSET:
                begin
                    top_d.rdata[EVT_W-1:0] = top_q.irq_stat;
                end
                IRQ_ENABLE_OFFSET:
                begin
                    top_d.rdata[EVT_W-1:0] = top_q.irq_en;
                end
                default:
                begin
                    top_d.rdata = '0;
                end
            endcase
        end

        if (apb_write)
        begin
            case (paddr)
                CSR_OFFSET:
                begin
                    top_d.sel =
                        pwdata[CSR_SEL_HI_BIT:CSR_SEL_LO_BIT];
                end
                IRQ_CLEAR_OFFSET:
                begin
                    clr = pwdata[EVT_W-1:0];
                end
                IRQ_ENABLE_OFFSET:
                begin
                    top_d.irq_en = pwdata[EVT_W-1:0];
                end
                default:
                begin
                    clr = '0;
                end
            endcase
        end

        // A new event beats a clear in the same cycle.
        top_d.irq_stat = (top_q.irq_stat & ~clr) | evt;
        top_d.irq = |(top_d.irq_stat & top_d.irq_en);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            top_q <= TOP_RESET;
        end
        else
        begin
            top_q <= top_d;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign prdata = top_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & top_q.slverr;
    assign supply_reset_out = top_q.rst_out;
    assign supply_reset_oe = ~top_q.rst_out;
    assign monitor_b_out = top_q.mon_b;
    assign monitor_b_oe = ~top_q.mon_b;
    assign monitor_c_out = top_q.mon_c;
    assign monitor_c_oe = ~top_q.mon_c;
    assign irq = top_q.irq;

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    power_up_a: assert property (
        $past(srst) |-> supply_reset_out ##1 supply_reset_out)
    else $error("Supply reset not high after power-up.");

    brown_out_a: assert property (
        !supply_ok_s |=> supply_reset_out)
    else $error("Supply reset low while supply is bad.");

    manual_start_a: assert property (
        manual_s |=> supply_reset_out [*2])
    else $error("Manual reset did not hold the supply reset.");

    hold_release_a: assert property (
        $fell(supply_reset_out) |->
        $past(top_q.seq == SEQ_COUNT && top_q.cnt == term_cnt - 1'b1
            && !fault))
    else $error("Supply reset released before the hold time.");

    sel_write_a: assert property (
        (apb_write && paddr == CSR_OFFSET) |=>
        top_q.sel == $past(pwdata[CSR_SEL_HI_BIT:CSR_SEL_LO_BIT]))
    else $error("Hold select write not taken.");

    mon_high_a: assert property (
        (mon_b_s && mon_c_s) |=> (monitor_b_out && monitor_c_out))
    else $error("Monitor output not high above trip.");

    mon_low_a: assert property (
        (!mon_b_s || !mon_c_s) |=> !(monitor_b_out && monitor_c_out))
    else $error("Monitor output not low below trip.");

    status_copy_a: assert property (
        ##1 (top_q.lat_b == $past(monitor_b_out) &&
        top_q.lat_c == $past(monitor_c_out)))
    else $error("Latched monitor bits do not follow outputs.");

    status_read_a: assert property (
        (apb_setup && paddr == CSR_OFFSET) |=>
        prdata[CSR_MON_B_BIT] == $past(top_q.lat_b) &&
        prdata[CSR_MON_C_BIT] == $past(top_q.lat_c))
    else $error("Latched monitor bits not returned on read.");

    mon_c_follow_a: assert property (
        monitor_c_out == $past(mon_c_s))
    else $error("Monitor C output delayed.");

    mon_b_follow_a: assert property (
        $changed(mon_b_s) |=> monitor_b_out == $past(mon_b_s))
    else $error("Monitor B output delayed.");

    count_step_a: assert property (
        (top_q.seq == SEQ_COUNT && !fault &&
        top_q.cnt != term_cnt - 1'b1) |=> top_q.cnt == $past(top_q.cnt) + 1'b1)
    else $error("Hold counter did not advance.");

    irq_set_wins_a: assert property (
        (evt != '0) |=> (top_q.irq_stat & $past(evt)) == $past(evt))
    else $error("Event lost against a clear.");

endmodule // srm_top

/* tb/srm_sys_model.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------------------
// System side of the open-drain outputs
// ---------------------------------------------------------------------------
// Each line has a board pull-up, so a released line reads high. The device
// only ever pulls low, so this model never shows the last driven value.
module srm_sys_model
(
    // Pull-low enables from the device.
    input wire logic supply_reset_oe,
    input wire logic monitor_b_oe,
    input wire logic monitor_c_oe,
    // Resolved line levels seen by the system.
    output logic supply_reset_line,
    output logic monitor_b_line,
    output logic monitor_c_line
);
    assign supply_reset_line = (supply_reset_oe === 1'b1) ? 1'b0 : 1'b1;
    assign monitor_b_line = (monitor_b_oe === 1'b1) ? 1'b0 : 1'b1;
    assign monitor_c_line = (monitor_c_oe === 1'b1) ? 1'b0 : 1'b1;
endmodule // srm_sys_model

/* tb/supply_reset_and_monitor_logic_bench.sv */
`timescale 1ns/1ns

module supply_reset_and_monitor_logic_bench;
    import srm_pkg::*;
    // -----------------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------------
    // Short hold counts keep the run brief; all expectations use these.
    localparam int H0 = 20;
    localparam int H1 = 30;
    localparam int H2 = 40;
    localparam int H3 = 50;
    // A pin change reaches a registered output five edges later: three
    // stages, the agreeing stage, then the output or sequencer flop.
    localparam int PIN_LAT = 5;
    int hold[4] = '{H0, H1, H2, H3};
    logic clock, srst, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic supply_ok_in, manual_reset_in, monitor_b_in, monitor_c_in;
    logic supply_reset_out, supply_reset_oe, monitor_b_out, monitor_b_oe;
    logic monitor_c_out, monitor_c_oe, rst_line, b_line, c_line, err;
    int n_mismatch, tests_run, n0, n;

    srm_top #(.HOLD_CYC_0(H0), .HOLD_CYC_1(H1), .HOLD_CYC_2(H2),
        .HOLD_CYC_3(H3)) dut (.clock(clock), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok_in(supply_ok_in), .manual_reset_in(manual_reset_in),
        .monitor_b_in(monitor_b_in), .monitor_c_in(monitor_c_in),
        .supply_reset_out(supply_reset_out),
        .supply_reset_oe(supply_reset_oe), .monitor_b_out(monitor_b_out),
        .monitor_b_oe(monitor_b_oe), .monitor_c_out(monitor_c_out),
        .monitor_c_oe(monitor_c_oe), .irq(irq));

    srm_sys_model partner (.supply_reset_oe(supply_reset_oe),
        .monitor_b_oe(monitor_b_oe), .monitor_c_oe(monitor_c_oe),
        .supply_reset_line(rst_line), .monitor_b_line(b_line),
        .monitor_c_line(c_line));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // -----------------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // One APB transfer; waits on pready rather than assuming its timing.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts edges from a clearing fault until the reset output drops.
    task automatic rel(output int k);
        k = 0;
        do
        begin
            @(posedge clock);
            #1;
            k++;
        end while (supply_reset_out !== 1'b0 && k < 500);
    endtask

    task automatic pulse(output int k);
        @(posedge clock);
        manual_reset_in <= 1'b1;
        cyc(6);
        chk(supply_reset_out, 1'b1);
        chk(rst_line, 1'b1);
        @(posedge clock);
        manual_reset_in <= 1'b0;
        rel(k);
    endtask

    // -----------------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------------
    task automatic t_reset_and_map();
        cyc(1);
        chk({supply_reset_out, supply_reset_oe, monitor_b_out,
            monitor_c_out, irq}, 5'h10);
        apb(1'b0, CSR_OFFSET, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h10, 32'hf);
        chk(err, 1'b1);
    endtask

    task automatic t_power_up();
        @(posedge clock);
        supply_ok_in <= 1'b1;
        rel(n0);
        chk(n0, PIN_LAT + H0);
    endtask

    task automatic t_irq_and_manual();
        apb(1'b1, IRQ_CLEAR_OFFSET, 32'hf);
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        pulse(n);
        chk(n, n0);
        apb(1'b1, IRQ_STATUS_OFFSET, 32'h0);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h3);
        chk(irq, 1'b0);
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h3);
        apb(1'b0, IRQ_ENABLE_OFFSET, 32'h0);
        chk(rd, 32'h3);
        cyc(2);
        chk(irq, 1'b1);
        apb(1'b0, IRQ_CLEAR_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, IRQ_CLEAR_OFFSET, 32'h1);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h2);
        cyc(2);
        chk(irq, 1'b1);
        apb(1'b1, IRQ_CLEAR_OFFSET, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
    endtask

    // Each selection must stretch the release by exactly its count delta.
    task automatic t_select();
        for (int s = 1; s < 4; s++)
        begin
            apb(1'b1, CSR_OFFSET, s);
            apb(1'b0, CSR_OFFSET, 32'h0);
            chk(rd, s);
            pulse(n);
            chk(n - n0, hold[s] - H0);
        end
    endtask

    // Monitors are exercised while the supply reset is held, so any
    // coupling to the reset delay would show.
    task automatic t_brown_out_monitors();
        @(posedge clock);
        supply_ok_in <= 1'b0;
        monitor_b_in <= 1'b1;
        cyc(PIN_LAT);
        chk({monitor_b_out, b_line}, 2'h3);
        chk(monitor_c_out, 1'b0);
        chk(supply_reset_out, 1'b1);
        @(posedge clock);
        monitor_c_in <= 1'b1;
        cyc(PIN_LAT);
        chk({monitor_c_out, c_line}, 2'h3);
        apb(1'b0, CSR_OFFSET, 32'h0);
        chk(rd, 32'h1f);
        monitor_b_in <= 1'b0;
        cyc(PIN_LAT);
        chk({monitor_b_out, b_line, monitor_c_out}, 3'h1);
        @(posedge clock);
        monitor_c_in <= 1'b0;
        cyc(PIN_LAT);
        chk({monitor_c_out, c_line}, 2'h0);
        apb(1'b0, CSR_OFFSET, 32'h0);
        chk(rd, 32'h13);
        n = 0;
        repeat (80)
        begin
            cyc(1);
            if (supply_reset_out !== 1'b1)
                n++;
        end
        chk(n, 0);
        @(posedge clock);
        supply_ok_in <= 1'b1;
        rel(n);
        chk(n - n0, H3 - H0);
    endtask

    // -----------------------------------------------------------------------
    // Run control
    // -----------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        supply_ok_in = 1'b0;
        manual_reset_in = 1'b0;
        monitor_b_in = 1'b0;
        monitor_c_in = 1'b0;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        t_reset_and_map();
        t_power_up();
        t_irq_and_manual();
        t_select();
        t_brown_out_monitors();
        report_and_stop();
    end
endmodule // supply_reset_and_monitor_logic_bench
